// >>> timer_consts.svh
// Purpose: Port addresses, bit positions and fixed values of the timer.
// Assumes: Included by bare name from design files.
// Notes: Definitions only.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
// ==========================================================
// I/O port addresses
`define PORT_TICK_CNT 16'h0040
`define PORT_TONE_CNT 16'h0042
`define PORT_CTL_A 16'h0043
`define PORT_WD_CNT 16'h0044
`define PORT_CTL_B 16'h0047
`define PORT_SYS_B 16'h0061
`define PORT_SYS_A 16'h0092
// ==========================================================
// Field positions and codes
`define SYSB_GATE2 0
`define SYSB_SPKEN 1
`define SYSB_OUT2 5
`define SYSB_CLRIRQ 7
`define SYSA_WDTO 4
`define SEL_TICK 2'h0
`define SEL_TONE 2'h2
`define SEL_WD 2'h0
`define RW_FIELD_LATCH 2'h0
`define RW_FIELD_LO 2'h1
`define IRQ0_VEC 8'h08
`define RD_UNMAPPED 8'hFF
`define WD_CTL_TAIL 4'h0
`endif

// >>> timer_pkg.sv
// Purpose: Types shared by the timer channels.
// Assumes: None.
// Notes: Mode codes 6 and 7 fold onto 2 and 3 when written.
package timer_pkg;
    typedef enum logic [1:0] {
        RW_LATCH = 2'h0,
        RW_LO = 2'h1,
        RW_HI = 2'h2,
        RW_LOHI = 2'h3
    } rw_t;
    typedef enum logic [2:0] {
        MODE_TC = 3'h0,
        MODE_ONESHOT = 3'h1,
        MODE_RATE = 3'h2,
        MODE_SQUARE = 3'h3,
        MODE_SWSTROBE = 3'h4,
        MODE_HWSTROBE = 3'h5
    } mode_t;
endpackage

// >>> pin_sync.sv
// Purpose: Two-flop synchroniser with rising edge pulse.
// Assumes: Pin is asynchronous to clk_sys.
// Notes: Edge is taken from the second and third flops only.
`timescale 1ns/10ps
module pin_sync (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic pin, // Asynchronous input
    output logic rise // One-cycle pulse on rising edge
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    // ==========================================================
    // Synchroniser chain
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else if (ce) begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end
    assign rise = ce & s2_r & ~s3_r;
endmodule

// >>> timer_channel.sv
// Purpose: One presettable down counter with six counting modes.
// Assumes: cnt_tick is a one-cycle pulse per counting clock.
// Notes: W is 16 or 8; W=8 is driven with low-byte binary mode 0 only.
`timescale 1ns/10ps
module timer_channel
    import timer_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic cnt_tick, // Counting clock pulse
    input wire logic gate, // Gate level
    input wire logic ctl_wr, // Control byte strobe
    input wire logic [5:0] ctl_data, // Control bits 5-0
    input wire logic cnt_wr, // Count byte write strobe
    input wire logic cnt_rd, // Count byte read strobe
    input wire logic [7:0] wdata, // Written byte
    output logic [7:0] rdata, // Byte that a read returns
    output logic out // Channel output
);
    localparam logic [W-1:0] ONE = W'(1);
    localparam logic [W-1:0] TWO = W'(2);
    mode_t mode_r;
    rw_t rw_r;
    logic bcd_r;
    logic [W-1:0] cr_r;
    logic [W-1:0] cnt_r;
    logic [W-1:0] ol_r;
    logic latched_r, load_r, have_r, run_r, out_r;
    logic wlo_r, rlo_r, gate_d_r, trig_r;

    // BCD-aware decrement by one
    function automatic logic [W-1:0] dec1(input logic [W-1:0] v,
                                          input logic bcd);
        logic [W-1:0] r;
        logic brw;
        r = v;
        brw = 1'b1;
        if (!bcd) begin
            r = v - ONE;
        end else begin
            for (int i = 0; i < W / 4; i++) begin
                if (brw) begin
                    if (r[4*i+:4] == 4'h0) begin
                        r[4*i+:4] = 4'h9;
                    end else begin
                        r[4*i+:4] = r[4*i+:4] - 4'h1;
                        brw = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Decode of control and count bytes
    wire is_latch = ctl_data[5:4] == RW_LATCH;
    // Codes x10 and x11 fold onto modes 2 and 3
    wire [2:0] mode_in = ctl_data[3:1];
    wire [2:0] mode_fold = ctl_data[2] ? {2'h1, ctl_data[1]} : mode_in;
    wire wr_hi = rw_r == RW_HI || (rw_r == RW_LOHI && wlo_r);
    wire wr_done = cnt_wr && (rw_r != RW_LOHI || wlo_r);
    wire rd_hi = rw_r == RW_HI || (rw_r == RW_LOHI && rlo_r);
    wire rd_done = cnt_rd && (rw_r != RW_LOHI || rlo_r);
    wire [15:0] cr16 = 16'(cr_r);
    wire [15:0] cr_wr16 = (rw_r == RW_HI) ? {wdata, 8'h00} :
                          wr_hi ? {wdata, cr16[7:0]} : {8'h00, wdata};
    wire [15:0] rd16 = 16'(latched_r ? ol_r : cnt_r);
    wire [W-1:0] nxt1 = dec1(cnt_r, bcd_r);
    wire [W-1:0] nxt2 = dec1(nxt1, bcd_r);
    wire [W-1:0] cr_even = {cr_r[W-1:1], 1'b0};
    wire m0 = mode_r == MODE_TC;
    wire m4 = mode_r == MODE_SWSTROBE;
    wire m1 = mode_r == MODE_ONESHOT;
    wire m5 = mode_r == MODE_HWSTROBE;
    wire m2 = mode_r == MODE_RATE;
    wire m3 = mode_r == MODE_SQUARE;
    assign rdata = rd_hi ? rd16[15:8] : rd16[7:0];
    assign out = out_r;

    // ==========================================================
    // Programming, read sequencing and counting
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mode_r <= MODE_TC;
            rw_r <= RW_LO;
            bcd_r <= 1'b0;
            cr_r <= '0;
            cnt_r <= '0;
            ol_r <= '0;
            {latched_r, load_r, have_r, run_r, out_r} <= 5'h00;
            // Gate history starts high so reset makes no false trigger
            {wlo_r, rlo_r, gate_d_r, trig_r} <= 4'h2;
        end else if (ce) begin
            gate_d_r <= gate;
            if (cnt_tick) trig_r <= 1'b0;
            if (gate && !gate_d_r) trig_r <= 1'b1;
            if (ctl_wr && is_latch) begin
                if (!latched_r) begin
                    ol_r <= cnt_r;
                    latched_r <= 1'b1;
                end
            end else if (ctl_wr) begin
                mode_r <= mode_t'(mode_fold);
                rw_r <= rw_t'(ctl_data[5:4]);
                bcd_r <= ctl_data[0];
                out_r <= mode_fold != MODE_TC;
                {latched_r, load_r, have_r, run_r} <= 4'h0;
                {wlo_r, rlo_r} <= 2'h0;
            end else begin
                if (cnt_wr) begin
                    cr_r <= cr_wr16[W-1:0];
                    if (rw_r == RW_LOHI) wlo_r <= ~wlo_r;
                    if (m0) out_r <= 1'b0;
                    if (m0 && !wr_done) run_r <= 1'b0;
                    if (wr_done) begin
                        load_r <= 1'b1;
                        have_r <= 1'b1;
                    end
                end
                if (cnt_rd) begin
                    if (rw_r == RW_LOHI) rlo_r <= ~rlo_r;
                    if (rd_done) latched_r <= 1'b0;
                end
                if (!gate && (m2 || m3)) out_r <= 1'b1;
                if (cnt_tick && (m0 || m4)) begin
                    if (load_r && !cnt_wr) begin
                        cnt_r <= cr_r;
                        {load_r, run_r} <= 2'h1;
                        if (m4) out_r <= 1'b1;
                    end else if (run_r && gate) begin
                        cnt_r <= nxt1;
                        if (m0 && nxt1 == '0) out_r <= 1'b1;
                        if (m4) out_r <= nxt1 != '0;
                        if (m4 && nxt1 == '0) run_r <= 1'b0;
                    end else if (m4) begin
                        out_r <= 1'b1;
                    end
                end
                if (cnt_tick && (m1 || m5)) begin
                    if (trig_r && have_r) begin
                        cnt_r <= cr_r;
                        run_r <= 1'b1;
                        out_r <= ~m1;
                    end else if (run_r) begin
                        cnt_r <= nxt1;
                        out_r <= m1 ? nxt1 == '0 : nxt1 != '0;
                        if (nxt1 == '0) run_r <= 1'b0;
                    end else begin
                        out_r <= 1'b1;
                    end
                end
                if (cnt_tick && (m2 || m3) && have_r) begin
                    if (trig_r || (load_r && !run_r)) begin
                        cnt_r <= m3 ? cr_even : cr_r;
                        {load_r, run_r, out_r} <= 3'h3;
                    end else if (run_r && gate && m2) begin
                        cnt_r <= (cnt_r == ONE) ? cr_r : nxt1;
                        out_r <= cnt_r == ONE || nxt1 != ONE;
                        if (cnt_r == ONE) load_r <= 1'b0;
                    end else if (run_r && gate) begin
                        cnt_r <= (cnt_r <= TWO) ? cr_even : nxt2;
                        if (cnt_r <= TWO) out_r <= ~out_r;
                        if (cnt_r <= TWO) load_r <= 1'b0;
                    end
                end
            end
        end
    end
endmodule

// >>> system_timer.sv
// Purpose: Tick, tone and watchdog timer channels on byte-wide I/O ports.
// Assumes: One I/O strobe per access; timer_clk is an async pin.
// Notes: Port 0061 bits 0,1,5,7 and port 0092 bit 4 live here too.
`timescale 1ns/10ps
`include "timer_consts.svh"

// How it works
// - Tick channel gate is always on; counts on the 1.193 MHz pin.
// - Tick request latch sets on tick rise; clears on reset, ack 08, 0061.7.
// - Tone channel gate follows port 0061 bit 0; counts on same clock.
// - Tone output is read back as port 0061 bit 5.
// - Speaker drive is tone output AND port 0061 bit 1.
// - Watchdog runs mode 0 only, 8-bit binary, no BCD.
// - Watchdog gate is the tick request; clock is inverted tick output.
// - Watchdog decrements when request still set at tick rise; zero raises NMI.
// - Watchdog timeout sets port 0092 bit 4; disabling clears it.
// - Enabled watchdog inhibits after request pends past one tick period.
// - Inhibit never asserts while the watchdog is disabled.
// - Tick and tone are 16-bit binary/BCD; watchdog is 8-bit binary.
// - Control bytes at 0043 and 0047; counts go to count ports.
// - A new count never changes the programmed mode.
// - Counts load per mode; count reads return the output latch while latched, else the live count.
// - Two-byte sequencing is kept per channel across other accesses.
// - Tick/tone formats are low only, high only, or low then high.
// - Control byte ports are write-only and read back nothing stored.
// - At 0043 bits 7-6 pick tick (00) or tone (10); bits 5-4 format.
// - Bits 3-1 pick mode 0 to 5, x10 and x11 fold; bit 0 BCD.
// - Latch command freezes count until read; repeats are ignored.
// - At 0047 bits 7-6 are 00; bits 5-4 latch or low byte only.
module system_timer
    import timer_pkg::*;
(
    input wire logic clk_sys, // System clock, 125 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic ce, // Clock enable, freezes all state
    input wire logic timer_clk, // 1.193 MHz counting clock pin
    input wire logic [15:0] io_addr, // I/O port address
    input wire logic [7:0] io_wdata, // I/O write data
    input wire logic io_wr, // I/O write strobe
    input wire logic io_rd, // I/O read strobe
    output logic [7:0] io_rdata, // I/O read data, registered
    input wire logic inta, // Interrupt acknowledge strobe
    input wire logic [7:0] inta_vec, // Vector of that acknowledge
    input wire logic wd_enable, // Watchdog enable level
    output logic irq0, // Tick interrupt request
    output logic nmi, // Watchdog non-maskable interrupt
    output logic inhibit, // Tick/watchdog write inhibit
    output logic speaker // Speaker drive
);
    logic irq0_r;
    logic inhibit_r;
    logic nmi_r;
    logic wdto_r;
    logic gate2_r;
    logic spken_r;
    logic speaker_r;
    logic out0_d_r;
    logic wd_out_d_r;
    logic [7:0] rdata_r;
    logic clk_rise;
    logic out0;
    logic out2;
    logic wd_out;
    logic [7:0] rd_tick;
    logic [7:0] rd_tone;
    logic [7:0] rd_wd;

    // ==========================================================
    // Counting clock pin
    pin_sync u_clk_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .pin(timer_clk),
        .rise(clk_rise)
    );

    // ==========================================================
    // Port decode
    wire acc_wr = ce & io_wr;
    wire acc_rd = ce & io_rd;
    wire hit_tick = io_addr == `PORT_TICK_CNT;
    wire hit_tone = io_addr == `PORT_TONE_CNT;
    wire hit_ctla = io_addr == `PORT_CTL_A;
    wire hit_wd = io_addr == `PORT_WD_CNT;
    wire hit_ctlb = io_addr == `PORT_CTL_B;
    wire hit_sysb = io_addr == `PORT_SYS_B;
    wire hit_sysa = io_addr == `PORT_SYS_A;
    wire [1:0] sel = io_wdata[7:6];
    wire [1:0] rwf = io_wdata[5:4];
    wire ctl_tick = acc_wr & hit_ctla & sel == `SEL_TICK;
    wire ctl_tone = acc_wr & hit_ctla & sel == `SEL_TONE;
    wire ctl_wd = acc_wr & hit_ctlb & sel == `SEL_WD &
                  (rwf == `RW_FIELD_LATCH || rwf == `RW_FIELD_LO);
    wire wr_sysb = acc_wr & hit_sysb;
    wire rd_sysb = acc_rd & hit_sysb;

    // Writes to tick and watchdog channels drop while inhibited
    wire tick_ctl_ok = ctl_tick & ~inhibit_r;
    wire tick_wr_ok = acc_wr & hit_tick & ~inhibit_r;
    wire wd_ctl_ok = ctl_wd & ~inhibit_r;
    wire wd_wr_ok = acc_wr & hit_wd & ~inhibit_r;

    // Watchdog control forced to mode 0, binary
    wire [5:0] wd_ctl_data = {rwf, `WD_CTL_TAIL};

    // ==========================================================
    // Tick channel: gate tied high
    timer_channel #(.W(16)) u_tick (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .cnt_tick(clk_rise),
        .gate(1'b1),
        .ctl_wr(tick_ctl_ok),
        .ctl_data(io_wdata[5:0]),
        .cnt_wr(tick_wr_ok),
        .cnt_rd(acc_rd & hit_tick),
        .wdata(io_wdata),
        .rdata(rd_tick),
        .out(out0)
    );

    // Tone channel: gate from port 0061 bit 0
    timer_channel #(.W(16)) u_tone (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .cnt_tick(clk_rise),
        .gate(gate2_r),
        .ctl_wr(ctl_tone),
        .ctl_data(io_wdata[5:0]),
        .cnt_wr(acc_wr & hit_tone),
        .cnt_rd(acc_rd & hit_tone),
        .wdata(io_wdata),
        .rdata(rd_tone),
        .out(out2)
    );

    // Watchdog rising tick output edge is the falling edge of its clock
    wire out0_rise = ce & out0 & ~out0_d_r;
    timer_channel #(.W(8)) u_wd (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .cnt_tick(out0_rise),
        .gate(irq0_r),
        .ctl_wr(wd_ctl_ok),
        .ctl_data(wd_ctl_data),
        .cnt_wr(wd_wr_ok),
        .cnt_rd(acc_rd & hit_wd),
        .wdata(io_wdata),
        .rdata(rd_wd),
        .out(wd_out)
    );
    wire wd_out_rise = ce & wd_out & ~wd_out_d_r;

    // ==========================================================
    // Tick request latch and inhibit; a set beats a clear
    wire irq_ack = inta & inta_vec == `IRQ0_VEC;
    wire irq_pclr = wr_sysb & io_wdata[`SYSB_CLRIRQ];
    wire irq_clr = irq_ack | irq_pclr;
    wire irq0_nxt = out0_rise | (irq0_r & ~irq_clr);
    wire inh_hold = inhibit_r & irq0_r & ~irq_clr;
    wire inh_nxt = wd_enable &
                   ((out0_rise & irq0_r) | inh_hold);
    wire wdto_nxt = wd_enable & (wd_out_rise | wdto_r);

    // Read data mux; control ports read as unmapped
    wire [7:0] sysb_rd = {2'h0, out2, 3'h0, spken_r, gate2_r};
    wire [7:0] sysa_rd = {3'h0, wdto_r, 4'h0};
    wire [7:0] rd_mux = hit_tick ? rd_tick :
                        hit_tone ? rd_tone :
                        hit_wd ? rd_wd :
                        hit_sysb ? sysb_rd :
                        hit_sysa ? sysa_rd : `RD_UNMAPPED;

    // ==========================================================
    // Status and port state registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq0_r <= 1'b0;
            inhibit_r <= 1'b0;
            nmi_r <= 1'b0;
            wdto_r <= 1'b0;
            out0_d_r <= 1'b0;
            wd_out_d_r <= 1'b0;
        end else if (ce) begin
            irq0_r <= irq0_nxt;
            inhibit_r <= inh_nxt;
            nmi_r <= wd_enable & wd_out;
            wdto_r <= wdto_nxt;
            out0_d_r <= out0;
            wd_out_d_r <= wd_out;
        end
    end

    // Port 0061 controls, speaker and read data
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gate2_r <= 1'b0;
            spken_r <= 1'b0;
            speaker_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (ce) begin
            if (wr_sysb) gate2_r <= io_wdata[`SYSB_GATE2];
            if (wr_sysb) spken_r <= io_wdata[`SYSB_SPKEN];
            speaker_r <= out2 & spken_r;
            if (io_rd) rdata_r <= rd_mux;
        end
    end

    assign irq0 = irq0_r;
    assign inhibit = inhibit_r;
    assign nmi = nmi_r;
    assign speaker = speaker_r;
    assign io_rdata = rdata_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    chk_irq_set_edge: assert property (
        out0_rise |=> irq0)
        else $error("tick request not set on tick rise");

    chk_irq_ack_clear: assert property (
        ce && irq_ack && !out0_rise |=> !irq0)
        else $error("tick request not cleared by acknowledge");

    chk_irq_port_clear: assert property (
        irq_pclr && !out0_rise |=> !irq0)
        else $error("tick request not cleared by port write");

    chk_irq_hold_set: assert property (
        ce && irq0 && !irq_clr |=> irq0)
        else $error("tick request dropped without a clear");

    chk_irq_no_spurious: assert property (
        ce && !irq0 && !out0_rise |=> !irq0)
        else $error("tick request set without tick rise");

    chk_tone_gate_follow: assert property (
        wr_sysb |=> gate2_r == $past(io_wdata[`SYSB_GATE2]))
        else $error("tone gate does not follow port bit");

    chk_tone_read_bit: assert property (
        rd_sysb |=> io_rdata[`SYSB_OUT2] == $past(out2))
        else $error("tone level not on read bit");

    chk_speaker_and: assert property (
        ce |=> speaker == $past(out2 && spken_r))
        else $error("speaker is not tone and enable");

    chk_nmi_cause: assert property (
        $rose(nmi) |-> $past(wd_out && wd_enable))
        else $error("NMI raised without watchdog output");

    chk_nmi_follow_out: assert property (
        ce && wd_enable && wd_out |=> nmi)
        else $error("NMI not raised by watchdog output");

    chk_wd_status_set: assert property (
        wd_enable && wd_out_rise ##1 wd_enable |-> wdto_r)
        else $error("timeout did not set status bit");

    chk_wd_status_hold: assert property (
        ce && wd_enable && wdto_r |=> wdto_r)
        else $error("timeout status bit lost while enabled");

    chk_wd_status_clr: assert property (
        ce && !wd_enable |=> !wdto_r)
        else $error("timeout status kept while disabled");

    chk_inhibit_cause: assert property (
        $rose(inhibit) |-> $past(irq0 && out0_rise))
        else $error("inhibit without pending tick request");

    chk_inhibit_needs_irq: assert property (
        inhibit |-> irq0)
        else $error("inhibit while no tick request pending");

    chk_inhibit_off_dis: assert property (
        ce && !wd_enable |=> !inhibit)
        else $error("inhibit active while watchdog disabled");

    chk_ctl_read_ff: assert property (
        ce && io_rd && (hit_ctla || hit_ctlb) |=> io_rdata == `RD_UNMAPPED)
        else $error("control port read returned stored state");

    chk_nmi_off_dis: assert property (
        ce && !wd_enable |=> !nmi)
        else $error("NMI active while watchdog disabled");

    cov_irq_rise: cover property ($rose(irq0));
    cov_nmi_rise: cover property ($rose(nmi));
    cov_inhibit_rise: cover property ($rose(inhibit));
    cov_speaker_rise: cover property ($rose(speaker));
endmodule

// >>> cpu_model.sv
// Purpose: Processor side of the byte-wide I/O port bus.
// Assumes: One strobe per access, launched at a falling edge.
// Notes: Released address and data show the inverse of the last value.
`timescale 1ns/10ps
module cpu_model (
    input wire logic clk_sys, // System clock
    output logic [15:0] io_addr, // Port address
    output logic [7:0] io_wdata, // Write data
    output logic io_wr, // Write strobe
    output logic io_rd, // Read strobe
    input wire logic [7:0] io_rdata // Read data
);
    // ==========================================
    // Bus cycles
    // Idle bus at time zero
    initial begin
        io_addr = 16'h0000;
        io_wdata = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
    end
    // Strobe held over one rising edge, then released
    task automatic cyc(input logic [15:0] a, input logic [7:0] d,
                       input logic w);
        @(negedge clk_sys);
        io_addr = a;
        io_wdata = d;
        io_wr = w;
        io_rd = !w;
        @(negedge clk_sys);
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_addr = ~a;
        io_wdata = ~d;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cyc(a, d, 1'b1);
    endtask
    // Read data is taken once the registered answer has landed
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        cyc(a, 8'h00, 1'b0);
        @(posedge clk_sys);
        #1 d = io_rdata;
    endtask
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the system timer block.
// Assumes: Counting pulses are made here at the 1.193 MHz rate.
// Notes: Pulses come in bursts so counts are known exactly.
`timescale 1ns/10ps
`include "timer_consts.svh"
module testbench;
    logic clk_sys, srst, ce, timer_clk, inta, wd_enable;
    logic [7:0] inta_vec, io_wdata, io_rdata, r, h, p;
    logic [15:0] io_addr, n;
    logic io_wr, io_rd, irq0, nmi, inhibit, speaker;
    logic [31:0] rv;
    logic [15:0] ro [3] = '{`PORT_CTL_A, `PORT_CTL_B, 16'h0050};
    int miscompares, total_checks, seed;
    // ==========================================
    // Instances
    system_timer u_system_timer (.clk_sys(clk_sys), .srst(srst),
        .ce(ce), .timer_clk(timer_clk), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata), .inta(inta), .inta_vec(inta_vec),
        .wd_enable(wd_enable), .irq0(irq0), .nmi(nmi),
        .inhibit(inhibit), .speaker(speaker));
    cpu_model u_cpu_model (.clk_sys(clk_sys), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata));
    // ==========================================
    // Helpers
    task automatic chk(input string nm, input logic [15:0] s, e);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Expected port 0061 read: tone level on bit 5, stored bits 1-0
    function automatic logic [15:0] sysb_exp(input logic t,
                                             input logic [1:0] b);
        return {10'h000, t, 3'h0, b};
    endfunction
    // Counting pulses at the slow rate, then let outputs settle
    task automatic pulses(input int c);
        repeat (c) begin
            #419 timer_clk = 1'b1;
            #419 timer_clk = 1'b0;
        end
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic ack(input logic [7:0] v);
        @(negedge clk_sys);
        inta = 1'b1;
        inta_vec = v;
        @(negedge clk_sys);
        inta = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ==========================================
    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        #300000;
        miscompares++;
        close_out();
    end
    // ==========================================
    // Main sequence
    initial begin
        seed = 32'h3ED5;
        {srst, ce, timer_clk, inta, wd_enable} = 5'b11000;
        inta_vec = 8'h00;
        repeat (6) @(negedge clk_sys);
        srst = 1'b0;
        chk("irq0", {15'h0000, irq0}, 16'h0000);
        chk("nmi", {15'h0000, nmi}, 16'h0000);
        foreach (ro[i]) begin
            u_cpu_model.rd(ro[i], r);
            chk("ctl read", {8'h00, r}, 16'h00FF);
        end
        // Tone held high with gate off, speaker enable random
        u_cpu_model.wr(`PORT_CTL_A, 8'h96);
        u_cpu_model.wr(`PORT_TONE_CNT, 8'h04);
        repeat (4) begin
            rv = $random(seed);
            p = {6'h00, rv[0], 1'b0};
            u_cpu_model.wr(`PORT_SYS_B, p);
            @(negedge clk_sys);
            chk("speaker", {15'h0000, speaker}, {15'h0000, rv[0]});
            u_cpu_model.rd(`PORT_SYS_B, r);
            chk("port61", {8'h00, r}, sysb_exp(1'b1, p[1:0]));
        end
        u_cpu_model.wr(`PORT_SYS_B, 8'h01);
        pulses(3);
        u_cpu_model.rd(`PORT_SYS_B, r);
        chk("tone low", {8'h00, r}, sysb_exp(1'b0, 2'h1));
        u_cpu_model.wr(`PORT_SYS_B, 8'h00);
        u_cpu_model.rd(`PORT_SYS_B, r);
        chk("tone high", {8'h00, r}, sysb_exp(1'b1, 2'h0));
        // Tick mode 0, two-byte count, latched reads
        rv = $random(seed);
        n = {4'h1, rv[11:0]};
        u_cpu_model.wr(`PORT_CTL_A, 8'h30);
        u_cpu_model.wr(`PORT_TICK_CNT, n[7:0]);
        u_cpu_model.wr(`PORT_TICK_CNT, n[15:8]);
        pulses(3);
        u_cpu_model.wr(`PORT_CTL_A, 8'h00);
        pulses(2);
        u_cpu_model.wr(`PORT_CTL_A, 8'h00);
        u_cpu_model.rd(`PORT_TICK_CNT, r);
        u_cpu_model.rd(`PORT_SYS_B, h);
        u_cpu_model.rd(`PORT_TICK_CNT, h);
        chk("latched", {h, r}, n - 16'h0002);
        u_cpu_model.wr(`PORT_CTL_A, 8'h00);
        u_cpu_model.rd(`PORT_TICK_CNT, r);
        u_cpu_model.rd(`PORT_TICK_CNT, h);
        chk("relatch", {h, r}, n - 16'h0004);
        // Tick rate mode, request set and cleared two ways
        rv = $random(seed);
        n = {14'h0000, rv[1:0]} + 16'h0002;
        u_cpu_model.wr(`PORT_CTL_A, 8'h14);
        u_cpu_model.wr(`PORT_TICK_CNT, n[7:0]);
        pulses(2 * n + 1);
        chk("irq0 set", {15'h0000, irq0}, 16'h0001);
        u_cpu_model.wr(`PORT_SYS_B, 8'h80);
        @(negedge clk_sys);
        chk("irq0 clr", {15'h0000, irq0}, 16'h0000);
        pulses(n + 1);
        ack(8'h09);
        chk("irq0 vec", {15'h0000, irq0}, 16'h0001);
        ack(`IRQ0_VEC);
        chk("irq0 ack", {15'h0000, irq0}, 16'h0000);
        // Pending request with the watchdog off, then on
        pulses(3 * n);
        chk("inhibit off", {15'h0000, inhibit}, 16'h0000);
        u_cpu_model.wr(`PORT_SYS_B, 8'h80);
        u_cpu_model.wr(`PORT_CTL_B, 8'h10);
        u_cpu_model.wr(`PORT_WD_CNT, 8'h02);
        wd_enable = 1'b1;
        pulses(10 * n);
        chk("nmi", {15'h0000, nmi}, 16'h0001);
        chk("inhibit", {15'h0000, inhibit}, 16'h0001);
        u_cpu_model.rd(`PORT_SYS_A, r);
        chk("timeout", {8'h00, r}, 16'h0010);
        // Reprogramming the watchdog while inhibited must be dropped
        u_cpu_model.wr(`PORT_CTL_B, 8'h10);
        @(negedge clk_sys);
        chk("nmi kept", {15'h0000, nmi}, 16'h0001);
        wd_enable = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("nmi off", {15'h0000, nmi}, 16'h0000);
        chk("inh off", {15'h0000, inhibit}, 16'h0000);
        u_cpu_model.rd(`PORT_SYS_A, r);
        chk("timeout clr", {8'h00, r}, 16'h0000);
        close_out();
    end
endmodule
